// ### dv/smi_extended_register_access_bench.sv
// Bench joining station and device over the management link
`timescale 1ns/1ps
`default_nettype none
module smi_extended_register_access_bench;
  localparam int HALF  = 6;
  localparam int LIMIT = 95000;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, active;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, seed, s;
  logic [4:0]  straps, phy_address, own, r;
  logic [15:0] access_control, address_pointer, q;
  logic [15:0] mem [32];
  logic [15:0] pv [3];
  logic [15:0] dv [3];
  logic [4:0]  devs [3];
  int          failures, num_checks, cycles;
  ////////////////////////////////
  smi_if link();
  smi_station #(.HALF(HALF)) smi_station_i (.pclk(pclk), .presetn(presetn), .ce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .smi(link));
  smi_device smi_device_i (.pclk(pclk), .presetn(presetn), .ce(1'b1),
    .phy_address_straps(straps), .smi(link), .phy_address(phy_address),
    .access_control(access_control), .address_pointer(address_pointer),
    .frame_active(active));
  smi_link_chk #(.HALF(HALF)) smi_link_chk_i (.pclk(pclk), .presetn(presetn),
    .mdc(link.mdc), .dev_o(link.dev_o), .dev_oe(link.dev_oe), .sta_o(link.sta_o),
    .sta_oe(link.sta_oe));
  ////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Holds the request until pready is sampled; one idle cycle keeps drivers apart
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dat,
                     output logic [31:0] rdat);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= dat;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rdat = prdata;
    err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic frm(input logic w, input logic [4:0] a, input logic [4:0] ra,
                     input logic [15:0] v, output logic [15:0] rv);
    logic [31:0] st;
    apb(1'b1, 8'h00, {5'h00, w, a, ra, v}, st);
    st = 32'h00000001;
    while (st[0] !== 1'b0)
      apb(1'b0, 8'h04, 32'h00000000, st);
    apb(1'b0, 8'h08, 32'h00000000, st);
    rv = st[15:0];
  endtask
  task automatic wr(input logic [4:0] ra, input logic [15:0] v);
    frm(1'b1, own, ra, v, q);
  endtask
  task automatic rd(input logic [4:0] ra, input logic [15:0] e);
    frm(1'b0, own, ra, 16'h0000, q);
    chk(q, e);
    // Device must be back in idle once the station reports the frame done
    chk({15'h0000, active}, 16'h0000);
  endtask
  task automatic ctrl(input logic [1:0] fn, input logic [4:0] dev);
    wr(5'h0D, {fn, 9'h000, dev});
  endtask
  task automatic point(input logic [4:0] dev, input logic [15:0] ptr);
    ctrl(2'b00, dev);
    wr(5'h0E, ptr);
    ctrl(2'b01, dev);
  endtask
  ////////////////////////////////
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      failures++;
      complete_run();
    end
  end
  initial
  begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h00000000; failures = 0; num_checks = 0; cycles = 0;
    foreach (mem[i]) mem[i] = 16'h0000;
    devs = '{5'h1F, 5'h03, 5'h07};
    seed = xs(32'h0816);
    own = seed[4:0];
    straps = own;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    chk({11'h000, phy_address}, {11'h000, own});
    // Straps move after capture; every later frame still needs the latched address
    straps <= ~own;
    for (int k = 0; k < 6; k++)
    begin
      seed = xs(seed);
      r = (k == 0) ? 5'h00 : (k == 1) ? 5'h1F : seed[20:16];
      if (r == 5'h0D || r == 5'h0E) r = 5'h10;
      mem[r] = seed[15:0];
      wr(r, mem[r]);
      rd(r, mem[r]);
    end
    frm(1'b1, own ^ 5'h01, r, ~mem[r], q);
    frm(1'b0, own ^ 5'h01, r, 16'h0000, q);
    chk(q, 16'hFFFF);
    rd(r, mem[r]);
    apb(1'b0, 8'h0C, 32'h00000000, s);
    chk({15'h0000, err}, 16'h0001);
    $display("direct access test done");
    for (int i = 0; i < 3; i++)
    begin
      seed = xs(seed);
      pv[i] = seed[15:0] | 16'h0020;
      dv[i] = seed[31:16];
      ctrl(2'b00, devs[i]);
      chk(access_control, {2'b00, 9'h000, devs[i]});
      wr(5'h0E, pv[i]);
      chk(address_pointer, pv[i]);
      ctrl(2'b01, devs[i]);
      wr(5'h0E, ~dv[i]);
      chk(address_pointer, pv[i]);
      rd(5'h0E, ~dv[i]);
      ctrl(2'b11, devs[i]);
      rd(5'h0E, ~dv[i]);
      chk(address_pointer, pv[i]);
      wr(5'h0E, dv[i]);
      chk(address_pointer, pv[i] + 16'h0001);
      ctrl(2'b00, devs[i]);
      rd(5'h0E, pv[i] + 16'h0001);
    end
    for (int i = 0; i < 3; i++)
    begin
      point(devs[i], pv[i]);
      rd(5'h0E, dv[i]);
    end
    $display("extended space test done");
    ctrl(2'b00, 5'h02);
    wr(5'h0E, 16'h1234);
    chk(address_pointer, pv[2]);
    rd(5'h0E, 16'h0000);
    ctrl(2'b10, 5'h1F);
    chk(access_control, 16'h801F);
    rd(5'h0E, 16'h0000);
    $display("refused access test done");
    point(5'h1F, {11'h000, r});
    rd(5'h0E, mem[r]);
    wr(5'h0E, dv[0]);
    mem[r] = dv[0];
    rd(r, mem[r]);
    point(5'h1F, 16'h000D);
    wr(5'h0E, 16'h5A5A);
    chk(access_control, 16'h401F);
    rd(5'h0E, 16'h0000);
    rd(5'h0D, 16'h401F);
    $display("standard register test done");
    complete_run();
  end
endmodule
`default_nettype wire

// ### dv/smi_link_chk.sv
// Assertions on the shared management link wires
`timescale 1ns/1ps
`default_nettype none
module smi_link_chk
#(
  parameter int HALF = 8
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic mdc,
  input wire logic dev_o,
  input wire logic dev_oe,
  input wire logic sta_o,
  input wire logic sta_oe
);
  logic [15:0] hi_ff;
  logic [15:0] lo_ff;
  logic [15:0] oe_ff;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////
  // Run lengths of clock phases and of device drive
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hi_ff <= 16'h0000;
      lo_ff <= 16'h0000;
      oe_ff <= 16'h0000;
    end
    else
    begin
      hi_ff <= mdc ? hi_ff + 16'h0001 : 16'h0000;
      lo_ff <= mdc ? 16'h0000 : lo_ff + 16'h0001;
      oe_ff <= dev_oe ? oe_ff + 16'h0001 : 16'h0000;
    end
  end
  ////////////////////////////////
  line_contention_a: assert property (!(dev_oe && sta_oe))
    else $error("both ends drive the data line");
  ta_zero_a: assert property ($rose(dev_oe) |-> !dev_o)
    else $error("device turnaround bit not zero");
  ta_release_a: assert property ($rose(dev_oe) |-> !sta_oe && !$past(sta_oe, 8))
    else $error("station held line into turnaround");
  read_length_a: assert property ($fell(dev_oe) |-> oe_ff == 16'(34 * HALF))
    else $error("device drive not seventeen bits long");
  // Drive changes only while mdc is low, so every rise sees a settled line
  dev_phase_a: assert property (($changed(dev_oe) || (dev_oe && $changed(dev_o))) |-> !mdc)
    else $error("device changed line while mdc high");
  sta_phase_a: assert property (($changed(sta_oe) || (sta_oe && $changed(sta_o))) |-> !mdc)
    else $error("station changed line while mdc high");
  mdc_high_a: assert property ($fell(mdc) |-> hi_ff == 16'(HALF))
    else $error("mdc high phase length wrong");
  mdc_low_a: assert property ($rose(mdc) |-> lo_ff >= 16'(HALF))
    else $error("mdc low phase too short");
  idle_release_a: assert property (lo_ff > 16'(HALF) |-> !sta_oe && !dev_oe)
    else $error("line driven while bus idle");
  cover property ($rose(dev_oe));
  cover property ($fell(dev_oe));
  cover property ($rose(sta_oe));
endmodule
`default_nettype wire

// ### verilog/smi_device.sv
// Management-frame slave with direct and indirect register access
//
// Implementation choice: register access over the management link; APB sits in the station.
`timescale 1ns/1ps
`default_nettype none
`include "smi_map.svh"
// Behaviour
// - Station keeps management clock at most 25 MHz
// - Tolerate stopped management clock while bus idle
// - Data line sampled on management clock rise
// - Answer only frames with own PHY address
// - Capture address from straps at reset
// - Station idles bus one cycle after reset
// - Register field selects one of 32 registers
// - Frames start with 0 then 1 after idle
// - Read turnaround: release, then drive 0, data
// - Station drives write turnaround as 1, 0
// - Indirect access to control and data ignored
// - Registers 0-31 reachable directly and indirectly
// - Control bits 4..0 steer indirect accesses
// - Supported spaces are 11111, 00011, 00111
// - Unsupported space: data register access ignored
// - Function bits: address, data, data+increment
// - Function 00 reaches the address pointer
// - Station loads pointer before extended access
// - Function 01 data access, pointer unchanged
// - Function 11 increments pointer after writes
// - Station sets pointer via 001F then address
module smi_device
  import smi_pkg::*;
#(
  parameter int EXT_AW = 5
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic [4:0]  phy_address_straps,
  smi_if.device            smi,
  output logic      [4:0]  phy_address,
  output logic      [15:0] access_control,
  output logic      [15:0] address_pointer,
  output logic             frame_active
);
  localparam int EXT_DEPTH = 1 << EXT_AW;

  if (EXT_AW < 1 || EXT_AW > 16)
  begin : g_bad_aw
    $error("EXT_AW must lie in 1..16");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and clock edges
  logic [6:0]  pins_s;
  logic        mdc_s;
  logic        bit_s;
  logic [4:0]  strap_s;
  logic        mdc_d_ff;
  logic        rise;
  logic        fall;

  sync2 #(.WIDTH(7)) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .en    (ce),
    .d     ({smi.mdc, smi.mdio, phy_address_straps}),
    .q     (pins_s)
  );

  assign mdc_s   = pins_s[6];
  assign bit_s   = pins_s[5];
  assign strap_s = pins_s[4:0];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mdc_d_ff <= 1'b0;
    else if (ce)
      mdc_d_ff <= mdc_s;
  end

  // No timeout on the clock: it may stop between frames
  assign rise = ce & mdc_s & ~mdc_d_ff;
  assign fall = ce & ~mdc_s & mdc_d_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Strap capture once the synchroniser has settled after reset
  logic [1:0]  strap_cnt_ff;
  logic [4:0]  phy_addr_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      strap_cnt_ff <= 2'h0;
      phy_addr_ff  <= 5'h00;
    end
    else if (ce && strap_cnt_ff != `SMI_STRAP_DONE)
    begin
      strap_cnt_ff <= strap_cnt_ff + 2'h1;
      if (strap_cnt_ff == `SMI_STRAP_CAPTURE)
        phy_addr_ff <= strap_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register storage and indirect decode
  logic [15:0] std_ff [`SMI_STD_LIMIT];
  logic [15:0] ext_ff [3][EXT_DEPTH];
  logic [15:0] acr_ff;
  logic [15:0] ptr_ff;
  mmd_func_t   func;
  logic [4:0]  devad;
  logic        devad_ok;
  logic        ind_ok;
  logic        ind_std;
  logic        ind_skip;
  logic [1:0]  space;
  logic [15:0] ind_rd;

  always_comb
  begin
    func     = mmd_func_t'(acr_ff[`SMI_FUNC_MSB:`SMI_FUNC_LSB]);
    devad    = acr_ff[`SMI_DEVAD_MSB:0];
    devad_ok = (devad == `SMI_DEVAD_VENDOR) || (devad == `SMI_DEVAD_EEE_PCS) ||
               (devad == `SMI_DEVAD_EEE_AN);
    ind_ok   = devad_ok && (func != fn_bad);
    ind_std  = (devad == `SMI_DEVAD_VENDOR) && (ptr_ff < `SMI_STD_LIMIT);
    ind_skip = ind_std && ((ptr_ff[4:0] == `SMI_REG_ACCESS_CTRL) ||
               (ptr_ff[4:0] == `SMI_REG_ADDRESS_DATA));
    if (devad == `SMI_DEVAD_EEE_PCS)
      space = 2'h1;
    else if (devad == `SMI_DEVAD_EEE_AN)
      space = 2'h2;
    else
      space = 2'h0;
    if (ind_skip)
      ind_rd = 16'h0000;
    else if (ind_std)
      ind_rd = std_ff[ptr_ff[4:0]];
    else
      ind_rd = ext_ff[space][ptr_ff[EXT_AW-1:0]];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame decoder
  dev_state_t  state_ff;
  logic [3:0]  cnt_ff;
  logic [11:0] hdr_ff;
  logic        last_ff;
  logic        match_ff;
  logic        read_ff;
  logic [4:0]  reg_ff;
  logic [14:0] wsh_ff;
  logic [15:0] rd_ff;
  logic [12:0] hdr_full;
  logic        hdr_ok;
  logic        wr_stb;
  logic [15:0] wr_data;
  logic [15:0] rd_value;

  assign hdr_full = {hdr_ff, bit_s};
  // Start bit, legal opcode and own address
  assign hdr_ok   = hdr_full[12] &&
                    ((hdr_full[11:10] == `SMI_OP_READ) || (hdr_full[11:10] == `SMI_OP_WRITE)) &&
                    (hdr_full[9:5] == phy_addr_ff);
  assign wr_stb   = rise && (state_ff == dev_data) && (cnt_ff == `SMI_DATA_LAST) &&
                    match_ff && !read_ff;
  assign wr_data  = {wsh_ff, bit_s};

  always_comb
  begin
    if (hdr_full[4:0] == `SMI_REG_ACCESS_CTRL)
      rd_value = acr_ff;
    else if (hdr_full[4:0] == `SMI_REG_ADDRESS_DATA)
      rd_value = !ind_ok ? 16'h0000 : (func == fn_addr) ? ptr_ff : ind_rd;
    else
      rd_value = std_ff[hdr_full[4:0]];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff <= dev_idle;
      cnt_ff   <= 4'h0;
      hdr_ff   <= 12'h000;
      last_ff  <= 1'b0;
      match_ff <= 1'b0;
      read_ff  <= 1'b0;
      reg_ff   <= 5'h00;
      wsh_ff   <= 15'h0000;
      rd_ff    <= 16'h0000;
    end
    else if (rise)
    begin
      case (state_ff)
        dev_idle:
        begin
          last_ff <= bit_s;
          if (!bit_s && last_ff)
          begin
            state_ff <= dev_hdr;
            cnt_ff   <= 4'h0;
          end
        end
        dev_hdr:
        begin
          hdr_ff <= hdr_full[11:0];
          cnt_ff <= cnt_ff + 4'h1;
          if (cnt_ff == `SMI_HDR_LAST)
          begin
            state_ff <= dev_ta;
            cnt_ff   <= 4'h0;
            match_ff <= hdr_ok;
            read_ff  <= hdr_full[11:10] == `SMI_OP_READ;
            reg_ff   <= hdr_full[4:0];
            rd_ff    <= rd_value;
          end
        end
        dev_ta:
        begin
          // Write turnaround bits carry nothing and are skipped
          cnt_ff <= cnt_ff + 4'h1;
          if (cnt_ff == `SMI_TA_LAST)
          begin
            state_ff <= dev_data;
            cnt_ff   <= 4'h0;
          end
        end
        dev_data:
        begin
          wsh_ff <= wr_data[14:0];
          cnt_ff <= cnt_ff + 4'h1;
          if (cnt_ff == `SMI_DATA_LAST)
          begin
            state_ff <= dev_idle;
            last_ff  <= 1'b0;
          end
        end
        default:
          state_ff <= dev_idle;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line driver, changes on the falling clock edge for margin
  logic        oe_ff;
  logic        o_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      oe_ff <= 1'b0;
      o_ff  <= 1'b0;
    end
    else if (fall)
    begin
      if (match_ff && read_ff && state_ff == dev_ta && cnt_ff == `SMI_TA_LAST)
      begin
        oe_ff <= 1'b1;
        o_ff  <= 1'b0;
      end
      else if (match_ff && read_ff && state_ff == dev_data)
      begin
        oe_ff <= 1'b1;
        o_ff  <= rd_ff[`SMI_DATA_LAST - cnt_ff];
      end
      else
      begin
        oe_ff <= 1'b0;
        o_ff  <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes, direct and indirect
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acr_ff <= `SMI_RESET_VALUE;
      ptr_ff <= `SMI_RESET_VALUE;
      for (int i = 0; i < `SMI_STD_LIMIT; i++)
        std_ff[i] <= `SMI_RESET_VALUE;
      for (int s = 0; s < 3; s++)
        for (int j = 0; j < EXT_DEPTH; j++)
          ext_ff[s][j] <= `SMI_RESET_VALUE;
    end
    else if (wr_stb)
    begin
      if (reg_ff == `SMI_REG_ACCESS_CTRL)
        acr_ff <= wr_data;
      else if (reg_ff == `SMI_REG_ADDRESS_DATA)
      begin
        if (ind_ok)
        begin
          if (func == fn_addr)
            ptr_ff <= wr_data;
          else
          begin
            if (!ind_std)
              ext_ff[space][ptr_ff[EXT_AW-1:0]] <= wr_data;
            else if (!ind_skip)
              std_ff[ptr_ff[4:0]] <= wr_data;
            if (func == fn_data_inc)
              ptr_ff <= ptr_ff + 16'h0001;
          end
        end
      end
      else
        std_ff[reg_ff] <= wr_data;
    end
  end

  assign smi.dev_o       = o_ff;
  assign smi.dev_oe      = oe_ff;
  assign phy_address     = phy_addr_ff;
  assign access_control  = acr_ff;
  assign address_pointer = ptr_ff;
  assign frame_active    = state_ff != dev_idle;
endmodule
`default_nettype wire

// ### verilog/smi_if.sv
// Management clock and shared data line between station and device
`timescale 1ns/1ps
`default_nettype none
interface smi_if;
  logic mdc;
  logic dev_o;
  logic dev_oe;
  logic sta_o;
  logic sta_oe;
  logic mdio;
  // Pull-up holds the line high when nobody drives
  assign mdio = dev_oe ? dev_o : (sta_oe ? sta_o : 1'b1);
  modport device (input mdc, input mdio, output dev_o, output dev_oe);
  modport station (output mdc, output sta_o, output sta_oe, input mdio);
endinterface
`default_nettype wire

// ### verilog/smi_map.svh
// Offsets, field positions, codes and timing counts of the management link
`ifndef SMI_MAP_SVH
`define SMI_MAP_SVH
`define SMI_REG_ACCESS_CTRL  5'h0D
`define SMI_REG_ADDRESS_DATA 5'h0E
`define SMI_STD_LIMIT        16'h0020
`define SMI_FUNC_MSB         15
`define SMI_FUNC_LSB         14
`define SMI_DEVAD_MSB        4
`define SMI_DEVAD_VENDOR     5'h1F
`define SMI_DEVAD_EEE_PCS    5'h03
`define SMI_DEVAD_EEE_AN     5'h07
`define SMI_OP_READ          2'h2
`define SMI_OP_WRITE         2'h1
`define SMI_TA_WRITE         2'h2
`define SMI_TA_READ          2'h3
`define SMI_HDR_LAST         4'hC
`define SMI_TA_LAST          4'h1
`define SMI_DATA_LAST        4'hF
`define SMI_RESET_VALUE      16'h0000
`define SMI_STRAP_CAPTURE    2'h2
`define SMI_STRAP_DONE       2'h3
`define SMI_PCLK_MHZ         50
`define SMI_MDC_MAX_MHZ      25
`define SMI_MDC_MIN_HALF     ((`SMI_PCLK_MHZ + 2 * `SMI_MDC_MAX_MHZ - 1) / (2 * `SMI_MDC_MAX_MHZ))
`define SMI_STA_HALF_DEFAULT 8
`define SMI_STA_MIN_HALF     6
`define SMI_STA_TA_IDX       7'd47
`define SMI_STA_DATA_IDX     7'd49
`define SMI_STA_LAST_IDX     7'd64
`define SMI_PREAMBLE         32'hFFFFFFFF
`define APB_CMD              8'h00
`define APB_STATUS           8'h04
`define APB_RDATA            8'h08
`define APB_CMD_WRITE_BIT    26
`define APB_STATUS_BUSY      0
`define APB_STATUS_DONE      1
`endif

// ### verilog/smi_pkg.sv
// Types shared by both ends of the management link
package smi_pkg;
  typedef enum logic [1:0] {
    dev_idle = 2'b00,
    dev_hdr  = 2'b01,
    dev_ta   = 2'b10,
    dev_data = 2'b11
  } dev_state_t;
  typedef enum logic [1:0] {
    sta_idle = 2'b00,
    sta_low  = 2'b01,
    sta_high = 2'b10
  } sta_state_t;
  typedef enum logic [1:0] {
    fn_addr     = 2'b00,
    fn_data     = 2'b01,
    fn_bad      = 2'b10,
    fn_data_inc = 2'b11
  } mmd_func_t;
endpackage

// ### verilog/smi_station.sv
// Management station: APB command registers driving management frames
`timescale 1ns/1ps
`default_nettype none
`include "smi_map.svh"
module smi_station
  import smi_pkg::*;
#(
  parameter int HALF = `SMI_STA_HALF_DEFAULT
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  smi_if.station           smi
);
  // Long enough half period for the device's sync and drive delay
  if (HALF < `SMI_MDC_MIN_HALF || HALF < `SMI_STA_MIN_HALF || HALF > 255)
  begin : g_bad_half
    $error("HALF out of range");
  end

  localparam logic [7:0] HALF_LAST = 8'(HALF - 1);

  logic        mdio_s;
  sta_state_t  state_ff;
  logic [7:0]  ph_ff;
  logic [6:0]  idx_ff;
  logic [64:0] frame_ff;
  logic        read_ff;
  logic        mdc_ff;
  logic        o_ff;
  logic        oe_ff;
  logic [14:0] rx_ff;
  logic [15:0] rdata_ff;
  logic [26:0] cmd_ff;
  logic        done_ff;
  logic [31:0] prdata_ff;
  logic        err_ff;
  logic        start;
  logic        frame_end;
  logic        bit_end;
  logic [6:0]  nxt_idx;

  sync2 #(.WIDTH(1)) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .en    (ce),
    .d     (smi.mdio),
    .q     (mdio_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB slave, zero wait states
  assign pready  = psel & penable;
  assign pslverr = psel & penable & err_ff;
  assign prdata  = prdata_ff;
  assign start   = ce && psel && penable && pwrite && (paddr == `APB_CMD) &&
                   (state_ff == sta_idle);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_ff <= 32'h00000000;
      err_ff    <= 1'b0;
    end
    else if (ce && psel && !penable)
    begin
      err_ff <= 1'b0;
      case (paddr)
        `APB_CMD:    prdata_ff <= {5'h00, cmd_ff};
        `APB_STATUS: prdata_ff <= {30'h00000000, done_ff, state_ff != sta_idle};
        `APB_RDATA:  prdata_ff <= {16'h0000, rdata_ff};
        default:
        begin
          prdata_ff <= 32'h00000000;
          err_ff    <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd_ff  <= 27'h0000000;
      done_ff <= 1'b0;
    end
    else if (ce)
    begin
      if (start)
        cmd_ff <= pwdata[26:0];
      // Completion beats a clear in the same cycle
      if (frame_end)
        done_ff <= 1'b1;
      else if (psel && penable && pwrite && paddr == `APB_STATUS &&
               pwdata[`APB_STATUS_DONE])
        done_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame engine: one idle bit, preamble, header, turnaround, data
  assign bit_end   = ce && (state_ff == sta_high) && (ph_ff == HALF_LAST);
  assign frame_end = bit_end && (idx_ff == `SMI_STA_LAST_IDX);
  assign nxt_idx   = idx_ff + 7'd1;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff <= sta_idle;
      ph_ff    <= 8'h00;
      idx_ff   <= 7'd0;
      frame_ff <= '0;
      read_ff  <= 1'b0;
      mdc_ff   <= 1'b0;
      o_ff     <= 1'b0;
      oe_ff    <= 1'b0;
      rx_ff    <= 15'h0000;
      rdata_ff <= 16'h0000;
    end
    else if (ce)
    begin
      case (state_ff)
        sta_idle:
        begin
          if (start)
          begin
            // Leading undriven bit keeps the bus idle after reset
            state_ff <= sta_low;
            ph_ff    <= 8'h00;
            idx_ff   <= 7'd0;
            read_ff  <= !pwdata[`APB_CMD_WRITE_BIT];
            frame_ff <= {`SMI_PREAMBLE, 2'b01,
                         pwdata[`APB_CMD_WRITE_BIT] ? `SMI_OP_WRITE : `SMI_OP_READ,
                         pwdata[25:16],
                         pwdata[`APB_CMD_WRITE_BIT] ? `SMI_TA_WRITE : `SMI_TA_READ,
                         pwdata[15:0], 1'b0};
            o_ff     <= 1'b1;
            oe_ff    <= 1'b0;
          end
        end
        sta_low:
        begin
          ph_ff <= ph_ff + 8'h01;
          if (ph_ff == HALF_LAST)
          begin
            state_ff <= sta_high;
            ph_ff    <= 8'h00;
            mdc_ff   <= 1'b1;
          end
        end
        sta_high:
        begin
          ph_ff <= ph_ff + 8'h01;
          if (ph_ff == HALF_LAST)
          begin
            // Sample late in the high phase, after the device settled
            if (read_ff && idx_ff >= `SMI_STA_DATA_IDX)
              rx_ff <= {rx_ff[13:0], mdio_s};
            ph_ff  <= 8'h00;
            mdc_ff <= 1'b0;
            if (idx_ff == `SMI_STA_LAST_IDX)
            begin
              state_ff <= sta_idle;
              oe_ff    <= 1'b0;
              if (read_ff)
                rdata_ff <= {rx_ff, mdio_s};
            end
            else
            begin
              state_ff <= sta_low;
              idx_ff   <= nxt_idx;
              o_ff     <= frame_ff[64];
              frame_ff <= {frame_ff[63:0], 1'b0};
              oe_ff    <= !(read_ff && nxt_idx >= `SMI_STA_TA_IDX);
            end
          end
        end
        default:
          state_ff <= sta_idle;
      endcase
    end
  end

  assign smi.mdc    = mdc_ff;
  assign smi.sta_o  = o_ff;
  assign smi.sta_oe = oe_ff;
endmodule
`default_nettype wire

// ### verilog/sync2.sv
// Two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module sync2
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             en,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] q_ff;

  if (WIDTH < 1)
  begin : g_bad_width
    $error("sync2 WIDTH must be at least 1");
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_ff <= '0;
      q_ff    <= '0;
    end
    else if (en)
    begin
      meta_ff <= d;
      q_ff    <= meta_ff;
    end
  end

  assign q = q_ff;
endmodule
`default_nettype wire
